/* File: logic/fpl_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides
module fpl_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 16
) (
  input wire logic i_clk, // Clock
  input wire logic i_reset_n, // Synchronous reset, active low
  input wire logic i_clear, // Drop all contents
  input wire logic i_in_valid, // Write request
  output logic o_in_ready, // Not full
  input wire logic [WIDTH-1:0] i_in_data, // Write data
  output logic o_out_valid, // Not empty
  input wire logic i_out_ready, // Read accept
  output logic [WIDTH-1:0] o_out_data // Head word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign o_in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign o_out_data = mem_r[rd_r];

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_r] <= i_in_data;
    end
  end

  // ----------------------------------------
  // Pointers and fill level
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || i_clear) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

/* File: logic/fpl_loader.sv */
// Passive parallel configuration loader, device end
`include "fpl_regs.svh"

// Operation
// - User mode keeps request, status and done high; request fall restarts.
// - After power-up status stays low for the whole power-on delay.
// - Done stays low from power-up through wait and data transfer.
// - Width mode picks data bits 7..0, 15..0 or 31..0; pins then freed.
// - Done rises only after the whole image arrived without error.
// - With init-done option, init-complete is driven low until init ends.
// - Done goes low within 600 ns of request falling.
// - Status goes low within 600 ns of request falling.
// - Status low at least 268 us, at most 1506 us if undelayed.
// - Status released within 1506 us of request rising unless held outside.
// - Host may stretch the wait; device follows request and held status.
// - Ratio one: one new word on every load-clock rising edge.
// - Internal oscillator init reaches user mode 175 to 437 us after done.
// - User init clock starts 4 clock periods after done, then 17408 periods.
// - Decompression changes the ratio for all widths; security only for the 16- and 32-bit widths.
module fpl_loader #(
  parameter int DATA_W = 32,
  parameter int FIFO_DEPTH = 16,
  parameter int POR_CYC = `FPL_STATUS_MIN_CYC,
  parameter int STATUS_MIN_CYC = `FPL_STATUS_MIN_CYC,
  parameter int INIT_CYC = `FPL_INIT_MIN_CYC,
  parameter int UINIT_PERIODS = `FPL_UINIT_PERIODS
) (
  input wire logic i_clk, // System clock
  input wire logic i_reset_n, // Synchronous reset, active low
  input wire logic i_config_request_n, // Reconfiguration request pin
  input wire logic i_status_n, // Status pin level
  output logic o_status_n, // Status pin drive value
  output logic o_status_n_oe, // Status pin drive enable
  output logic o_load_complete, // Image loaded flag pin
  input wire logic i_load_clock, // Load clock pin from host
  input wire logic [DATA_W-1:0] i_data, // Configuration data pins
  input wire logic [1:0] i_width_mode, // Bus width select
  input wire logic i_decompress_en, // Decompression feature on
  input wire logic i_security_en, // Design security feature on
  input wire logic [31:0] i_image_words, // Words in one image
  input wire logic i_user_clk_opt, // Use the user init clock
  input wire logic i_user_init_clock, // User init clock pin
  input wire logic i_init_done_opt, // Init-complete pin enabled
  output logic o_init_complete, // Init-complete pin drive value
  output logic o_init_complete_oe, // Init-complete pin drive enable
  output logic o_user_mode, // Device in user mode
  output logic o_data_pins_user, // Data pins freed for user I/O
  output logic o_error, // Transfer error seen
  output logic o_cfg_valid, // Configuration word available
  input wire logic i_cfg_ready, // Configuration word accepted
  output fpl_pkg::fpl_word_t o_cfg_word // Configuration word
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [3:0] fpl_ratio(input logic [1:0] w, input logic dec,
                                           input logic sec);
    logic [3:0] r;
    r = 4'h1;
    unique case (fpl_pkg::fpl_width_t'(w))
      fpl_pkg::FPL_W8: r = dec ? 4'h2 : 4'h1;
      fpl_pkg::FPL_W16: r = dec ? 4'h4 : (sec ? 4'h2 : 4'h1);
      fpl_pkg::FPL_W32: r = dec ? 4'h8 : (sec ? 4'h4 : 4'h1);
      default: r = 4'h1;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] fpl_mask(input logic [1:0] w);
    logic [31:0] m;
    m = 32'hFFFFFFFF;
    unique case (fpl_pkg::fpl_width_t'(w))
      fpl_pkg::FPL_W8: m = 32'h000000FF;
      fpl_pkg::FPL_W16: m = 32'h0000FFFF;
      fpl_pkg::FPL_W32: m = 32'hFFFFFFFF;
      default: m = 32'hFFFFFFFF;
    endcase
    return m;
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  fpl_pkg::fpl_state_t state_r;
  fpl_pkg::fpl_state_t state_nxt;
  logic [3:0] pins;
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;
  logic [3:0] lvl_r;
  logic [3:0] lvl_d_r;
  logic [DATA_W-1:0] d1_r;
  logic [DATA_W-1:0] d2_r;
  logic [DATA_W-1:0] d3_r;
  logic [DATA_W-1:0] d4_r;
  logic req_fall;
  logic req_high;
  logic stat_high;
  logic lclk_rise;
  logic lclk_fall;
  logic uclk_rise;
  logic [31:0] tmr_r;
  logic [31:0] wc_r;
  logic [3:0] beat_r;
  logic [1:0] falls_r;
  logic cu_done_r;
  logic [3:0] ratio;
  logic beat_last;
  logic push;
  logic fifo_ready;
  logic last_word;
  fpl_pkg::fpl_word_t word;

  assign pins = {i_user_init_clock, i_load_clock, i_status_n, i_config_request_n};

  // ----------------------------------------
  // Pin synchronisers and filters
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      s1_r <= `FPL_PIN_RST;
      s2_r <= `FPL_PIN_RST;
      s3_r <= `FPL_PIN_RST;
      lvl_r <= `FPL_PIN_RST;
      lvl_d_r <= `FPL_PIN_RST;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < 4; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          lvl_r[i] <= s3_r[i];
        end
      end
      lvl_d_r <= lvl_r;
    end
  end

  // Data pins follow the clock path stage by stage
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      d1_r <= '0;
      d2_r <= '0;
      d3_r <= '0;
      d4_r <= '0;
    end else begin
      d1_r <= i_data;
      d2_r <= d1_r;
      d3_r <= d2_r;
      d4_r <= d3_r;
    end
  end

  assign req_fall = ~lvl_r[`FPL_PIN_REQ] & lvl_d_r[`FPL_PIN_REQ];
  assign req_high = lvl_r[`FPL_PIN_REQ];
  assign stat_high = lvl_r[`FPL_PIN_STAT];
  assign lclk_rise = lvl_r[`FPL_PIN_LCLK] & ~lvl_d_r[`FPL_PIN_LCLK];
  assign lclk_fall = ~lvl_r[`FPL_PIN_LCLK] & lvl_d_r[`FPL_PIN_LCLK];
  assign uclk_rise = lvl_r[`FPL_PIN_UCLK] & ~lvl_d_r[`FPL_PIN_UCLK];

  // ----------------------------------------
  // Word assembly
  // ----------------------------------------
  // ratio from features
  assign ratio = fpl_ratio(i_width_mode, i_decompress_en, i_security_en);
  assign beat_last = (beat_r == ratio - 4'h1);
  assign push = (state_r == fpl_pkg::FPL_LOAD) & lclk_rise & beat_last;
  assign last_word = (wc_r + 32'h1 >= i_image_words);
  assign word.data = d4_r & fpl_mask(i_width_mode);
  assign word.width = fpl_pkg::fpl_width_t'(i_width_mode);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n || state_r != fpl_pkg::FPL_LOAD) begin
      beat_r <= '0;
      wc_r <= '0;
    end else if (lclk_rise) begin
      beat_r <= beat_last ? 4'h0 : beat_r + 4'h1;
      if (beat_last) begin
        wc_r <= wc_r + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // Word buffer
  // ----------------------------------------
  fpl_fifo #(
    .WIDTH($bits(fpl_pkg::fpl_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_clear(req_fall),
    .i_in_valid(push),
    .o_in_ready(fifo_ready),
    .i_in_data(word),
    .o_out_valid(o_cfg_valid),
    .i_out_ready(i_cfg_ready),
    .o_out_data(o_cfg_word)
  );

  // ----------------------------------------
  // Sequence control
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      fpl_pkg::FPL_POR: begin
        if (tmr_r >= 32'(POR_CYC)) begin
          state_nxt = fpl_pkg::FPL_RESET;
        end
      end
      fpl_pkg::FPL_RESET: begin
        if (req_high && tmr_r >= 32'(STATUS_MIN_CYC)) begin
          state_nxt = fpl_pkg::FPL_WAIT_STAT;
        end
      end
      fpl_pkg::FPL_WAIT_STAT: begin
        if (stat_high) begin
          state_nxt = fpl_pkg::FPL_LOAD;
        end
      end
      fpl_pkg::FPL_LOAD: begin
        if (!stat_high || (push && !fifo_ready)) begin
          state_nxt = fpl_pkg::FPL_ERR;
        end else if (push && last_word) begin
          state_nxt = fpl_pkg::FPL_FALLS;
        end
      end
      fpl_pkg::FPL_FALLS: begin
        if (lclk_fall && falls_r == `FPL_FALLS_TO_INIT - 2'h1) begin
          state_nxt = fpl_pkg::FPL_INIT;
        end
      end
      fpl_pkg::FPL_INIT: begin
        if (i_user_clk_opt) begin
          if (cu_done_r && uclk_rise && tmr_r + 32'h1 >= 32'(UINIT_PERIODS)) begin
            state_nxt = fpl_pkg::FPL_USER;
          end
        end else if (tmr_r + 32'h1 >= 32'(INIT_CYC)) begin
          state_nxt = fpl_pkg::FPL_USER;
        end
      end
      fpl_pkg::FPL_USER: begin
        state_nxt = fpl_pkg::FPL_USER;
      end
      fpl_pkg::FPL_ERR: begin
        state_nxt = fpl_pkg::FPL_ERR;
      end
    endcase
    if (req_fall && state_r != fpl_pkg::FPL_POR) begin
      state_nxt = fpl_pkg::FPL_RESET;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_r <= fpl_pkg::FPL_POR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Timer, restarted on each state change
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || state_nxt != state_r) begin
      tmr_r <= '0;
    end else if (state_r == fpl_pkg::FPL_INIT && i_user_clk_opt) begin
      if (!cu_done_r && tmr_r + 32'h1 >= 32'(`FPL_CU_CYC)) begin
        tmr_r <= '0;
      end else if (!cu_done_r || uclk_rise) begin
        tmr_r <= tmr_r + 32'h1;
      end
    end else if (tmr_r != 32'hFFFFFFFF) begin
      tmr_r <= tmr_r + 32'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n || state_r != fpl_pkg::FPL_INIT) begin
      cu_done_r <= 1'b0;
    end else if (i_user_clk_opt && tmr_r + 32'h1 >= 32'(`FPL_CU_CYC)) begin
      cu_done_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n || state_r != fpl_pkg::FPL_FALLS) begin
      falls_r <= '0;
    end else if (lclk_fall) begin
      falls_r <= falls_r + 2'h1;
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_status_n_oe <= 1'b1;
      o_load_complete <= 1'b0;
      o_init_complete_oe <= 1'b0;
      o_user_mode <= 1'b0;
      o_data_pins_user <= 1'b0;
      o_error <= 1'b0;
    end else begin
      o_status_n_oe <= (state_nxt == fpl_pkg::FPL_POR) ||
                       (state_nxt == fpl_pkg::FPL_RESET) ||
                       (state_nxt == fpl_pkg::FPL_ERR);
      o_load_complete <= (state_nxt == fpl_pkg::FPL_FALLS) ||
                         (state_nxt == fpl_pkg::FPL_INIT) ||
                         (state_nxt == fpl_pkg::FPL_USER);
      o_init_complete_oe <= i_init_done_opt &&
                            ((state_nxt == fpl_pkg::FPL_FALLS) ||
                             (state_nxt == fpl_pkg::FPL_INIT));
      o_user_mode <= (state_nxt == fpl_pkg::FPL_USER);
      o_data_pins_user <= (state_nxt == fpl_pkg::FPL_USER);
      o_error <= (state_nxt == fpl_pkg::FPL_ERR);
    end
  end

  // Open-drain pins only ever pull low
  assign o_status_n = 1'b0;
  assign o_init_complete = 1'b0;

endmodule

/* File: logic/fpl_pkg.sv */
// Types shared by the parallel configuration loader
package fpl_pkg;

  // ----------------------------------------
  // Bus width modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    FPL_W8 = 2'h0,
    FPL_W16 = 2'h1,
    FPL_W32 = 2'h2
  } fpl_width_t;

  // ----------------------------------------
  // Loader states, Gray along the usual path
  // ----------------------------------------
  typedef enum logic [2:0] {
    FPL_POR = 3'h0,
    FPL_RESET = 3'h1,
    FPL_WAIT_STAT = 3'h3,
    FPL_LOAD = 3'h2,
    FPL_FALLS = 3'h6,
    FPL_INIT = 3'h7,
    FPL_USER = 3'h5,
    FPL_ERR = 3'h4
  } fpl_state_t;

  // ----------------------------------------
  // One captured configuration word
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] data;
    fpl_width_t width;
  } fpl_word_t;

endpackage

/* File: logic/fpl_regs.svh */
// Timing figures and reset values of the parallel configuration loader
`ifndef FPL_REGS_SVH
`define FPL_REGS_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define FPL_CLK_PS 8000

// ----------------------------------------
// Times as printed
// ----------------------------------------
`define FPL_STATUS_MIN_US 268
`define FPL_INIT_MIN_US 175
`define FPL_INIT_MAX_US 437
`define FPL_LCLK_MAX_PERIOD_NS 10
`define FPL_CU_PERIODS 4
`define FPL_UINIT_PERIODS 17408

// ----------------------------------------
// Derived cycle counts, least times round up
// ----------------------------------------
`define FPL_STATUS_MIN_CYC ((`FPL_STATUS_MIN_US * 1000000 + `FPL_CLK_PS - 1) / `FPL_CLK_PS)
`define FPL_INIT_MIN_CYC ((`FPL_INIT_MIN_US * 1000000 + `FPL_CLK_PS - 1) / `FPL_CLK_PS)
`define FPL_CU_CYC \
  ((`FPL_CU_PERIODS * `FPL_LCLK_MAX_PERIOD_NS * 1000 + `FPL_CLK_PS - 1) / `FPL_CLK_PS)

// ----------------------------------------
// Pin layout and reset values
// ----------------------------------------
`define FPL_PIN_REQ 0
`define FPL_PIN_STAT 1
`define FPL_PIN_LCLK 2
`define FPL_PIN_UCLK 3
`define FPL_PIN_RST 4'h3
`define FPL_FALLS_TO_INIT 2'h2

`endif

/* File: tb/fpl_host_model.sv */
// Host model that drives the loader's configuration pins
module fpl_host_model (
  input wire logic i_clk, // Bench clock
  input wire logic i_status_n, // Status wire level
  output logic o_request_n, // Request pin
  output logic o_load_clock, // Load clock pin
  output logic [31:0] o_data, // Data pins
  output logic o_pull, // Holds status low
  output logic o_user_clock // User init clock pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int uc_cnt = 0;
  initial begin
    o_request_n = 1'b1;
    o_load_clock = 1'b0;
    o_data = 32'h0;
    o_pull = 1'b0;
    o_user_clock = 1'b0;
  end
  always @(negedge i_clk) begin
    uc_cnt <= (uc_cnt == 9) ? 0 : uc_cnt + 1;
    if (uc_cnt == 9) o_user_clock <= ~o_user_clock;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic pulse();
    cyc(10);
    o_load_clock = 1'b1;
    cyc(10);
    o_load_clock = 1'b0;
  endtask
  task automatic request(input int lo);
    o_request_n = 1'b0;
    cyc(lo);
    o_request_n = 1'b1;
  endtask
  task automatic hold(input logic v);
    o_pull = v;
  endtask
  task automatic wait_ready(output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 2000 && !ok; n++) begin
      cyc(1);
      ok = (i_status_n === 1'b1);
    end
    cyc(260);
  endtask
  task automatic word(input logic [31:0] d, input int r);
    o_data = d;
    repeat (r) pulse();
  endtask
  // last word's fall is first, one more, clock parked low
  task automatic finish_load();
    pulse();
    o_data = ~o_data;
  endtask
endmodule

/* File: tb/fpl_loader_monitor.sv */
// Concurrent checks on the parallel configuration loader ports
module fpl_loader_monitor #(
  parameter int POR_CYC = 50,
  parameter int STATUS_MIN_CYC = 40,
  parameter int INIT_CYC = 30,
  parameter int UINIT_PERIODS = 8
) (
  input wire logic i_clk, // Clock
  input wire logic i_reset_n, // Reset, active low
  input wire logic i_config_request_n, // Request pin
  input wire logic i_init_done_opt, // Init-complete option
  input wire logic i_user_clk_opt, // User clock option
  input wire logic o_status_n_oe, // Status pull
  input wire logic o_load_complete, // Done flag
  input wire logic o_init_complete_oe, // Init pull
  input wire logic o_user_mode, // User mode
  input wire logic o_data_pins_user, // Pins freed
  input wire logic o_error // Error flag
);
  // Pipeline slack on the status count
  localparam int ST_LO = STATUS_MIN_CYC - 2;
  localparam int ST_HI = POR_CYC + STATUS_MIN_CYC + 16;
  localparam int CU_LO = UINIT_PERIODS * 6;
  logic [31:0] low_cnt_r;
  logic [31:0] init_cnt_r;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // ----
  // Helper counters
  // ----
  always_ff @(posedge i_clk) begin
    low_cnt_r <= (o_status_n_oe && i_reset_n) ? low_cnt_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge i_clk) begin
    init_cnt_r <= (o_load_complete && !o_user_mode) ? init_cnt_r + 32'h1 : 32'h0;
  end
  // ----
  // Properties
  // ----
  property p_req_status; $fell(i_config_request_n) |-> ##[0:75] o_status_n_oe; endproperty
  a_req_status: assert property (p_req_status) else $error("status not low");
  property p_req_done; $fell(i_config_request_n) |-> ##[0:75] !o_load_complete; endproperty
  a_req_done: assert property (p_req_done) else $error("done not low");
  property p_user_levels;
    o_user_mode && i_config_request_n && $past(i_config_request_n, 8)
      |-> o_load_complete && !o_status_n_oe;
  endproperty
  a_user_levels: assert property (p_user_levels) else $error("user levels");
  property p_status_min; $fell(o_status_n_oe) |-> low_cnt_r >= ST_LO; endproperty
  a_status_min: assert property (p_status_min) else $error("status short");
  property p_status_max; $rose(i_config_request_n) |-> ##[0:ST_HI] !o_status_n_oe; endproperty
  a_status_max: assert property (p_status_max) else $error("status stuck");
  property p_done_clear; o_status_n_oe |-> !o_load_complete; endproperty
  a_done_clear: assert property (p_done_clear) else $error("done early");
  property p_err; o_error |-> o_status_n_oe && !o_load_complete && !o_user_mode; endproperty
  a_err: assert property (p_err) else $error("error levels");
  property p_pins; o_data_pins_user |-> o_user_mode && o_load_complete; endproperty
  a_pins: assert property (p_pins) else $error("pins freed early");
  property p_init_pull; o_init_complete_oe |-> i_init_done_opt && !o_user_mode; endproperty
  a_init_pull: assert property (p_init_pull) else $error("init pull");
  property p_init_min; $rose(o_user_mode) && !i_user_clk_opt |-> init_cnt_r >= INIT_CYC; endproperty
  a_init_min: assert property (p_init_min) else $error("init short");
  property p_uinit_min; $rose(o_user_mode) && i_user_clk_opt |-> init_cnt_r >= CU_LO; endproperty
  a_uinit_min: assert property (p_uinit_min) else $error("user init short");
endmodule

bind fpl_loader fpl_loader_monitor #(.POR_CYC(POR_CYC), .STATUS_MIN_CYC(STATUS_MIN_CYC),
  .INIT_CYC(INIT_CYC), .UINIT_PERIODS(UINIT_PERIODS)) i_mon (.i_clk(i_clk),
  .i_reset_n(i_reset_n), .i_config_request_n(i_config_request_n),
  .i_init_done_opt(i_init_done_opt), .i_user_clk_opt(i_user_clk_opt),
  .o_status_n_oe(o_status_n_oe), .o_load_complete(o_load_complete),
  .o_init_complete_oe(o_init_complete_oe), .o_user_mode(o_user_mode),
  .o_data_pins_user(o_data_pins_user), .o_error(o_error));

/* File: tb/fpl_loader_tb.sv */
// Self-checking bench for the parallel configuration loader
module fpl_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POR = 50, SMIN = 40, INIT = 30, UP = 8;
  logic i_clk = 1'b0;
  logic i_reset_n;
  logic [1:0] i_width_mode;
  logic i_decompress_en, i_security_en, i_cfg_ready;
  logic i_user_clk_opt, i_init_done_opt, rdy_en = 1'b0;
  logic [31:0] i_image_words;
  logic [31:0] seed = 32'h600E46C7;
  wire i_config_request_n, i_load_clock, i_user_init_clock, pull, i_status_n;
  wire [31:0] i_data;
  logic o_status_n, o_status_n_oe, o_load_complete, o_init_complete, o_init_complete_oe;
  logic o_user_mode, o_data_pins_user, o_error, o_cfg_valid;
  fpl_pkg::fpl_word_t o_cfg_word;
  fpl_pkg::fpl_word_t exp_q [$];
  int bad_count = 0, cmp_count = 0;
  always #4 i_clk = ~i_clk;
  assign i_status_n = !((o_status_n_oe && !o_status_n) || pull);
  fpl_loader #(.POR_CYC(POR), .STATUS_MIN_CYC(SMIN), .INIT_CYC(INIT), .UINIT_PERIODS(UP))
  i_dut (.i_clk, .i_reset_n, .i_config_request_n, .i_status_n, .o_status_n, .o_status_n_oe,
    .o_load_complete, .i_load_clock, .i_data, .i_width_mode, .i_decompress_en, .i_security_en,
    .i_image_words, .i_user_clk_opt, .i_user_init_clock, .i_init_done_opt, .o_init_complete,
    .o_init_complete_oe, .o_user_mode, .o_data_pins_user, .o_error, .o_cfg_valid, .i_cfg_ready,
    .o_cfg_word);
  fpl_host_model i_host (.i_clk, .i_status_n, .o_request_n(i_config_request_n),
    .o_load_clock(i_load_clock), .o_data(i_data), .o_pull(pull),
    .o_user_clock(i_user_init_clock));
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic int ratio(input logic [1:0] w, input logic d, input logic s);
    case (w)
      2'h0: return d ? 2 : 1;
      2'h1: return d ? 4 : (s ? 2 : 1);
      default: return d ? 8 : (s ? 4 : 1);
    endcase
  endfunction
  function automatic logic [31:0] mask(input logic [1:0] w);
    return (w == 2'h0) ? 32'h000000FF : (w == 2'h1) ? 32'h0000FFFF : 32'hFFFFFFFF;
  endfunction
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(negedge i_clk) i_cfg_ready <= rdy_en && ((rnd() & 32'h1) != 32'h0);
  always @(posedge i_clk) begin
    if (i_reset_n && o_cfg_valid === 1'b1 && i_cfg_ready === 1'b1) begin
      chk(exp_q.size() > 0 && o_cfg_word === exp_q[0], "config word");
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
  end
  // ----
  // One configuration cycle; mode 1 status fault, mode 2 overflow
  // ----
  task automatic run_cfg(input int n, input int stretch, input int mode);
    logic [31:0] d;
    logic ok;
    fpl_pkg::fpl_word_t e;
    int r, t, lo, hi;
    r = ratio(i_width_mode, i_decompress_en, i_security_en);
    i_image_words = (mode == 2) ? 40 : n;
    exp_q.delete();
    rdy_en = (mode != 2);
    i_host.request(260);
    chk(o_status_n_oe === 1'b1 && o_load_complete === 1'b0, "request answer");
    i_host.hold(stretch != 0);
    i_host.cyc(stretch);
    chk(o_load_complete === 1'b0 && o_error === 1'b0, "held status");
    i_host.hold(1'b0);
    i_host.wait_ready(ok);
    chk(ok, "status release");
    for (int i = 0; i < n; i++) begin
      d = rnd();
      e.data = d & mask(i_width_mode);
      e.width = fpl_pkg::fpl_width_t'(i_width_mode);
      exp_q.push_back(e);
      if (mode == 2 && i == 16) begin
        chk(o_error === 1'b0 && o_cfg_valid === 1'b1, "fifo full");
        rdy_en = 1'b1;
        for (t = 0; t < 200 && exp_q.size() > 1; t++) i_host.cyc(1);
        chk(o_cfg_valid === 1'b0, "fifo drained");
        rdy_en = 1'b0;
      end
      if (mode == 1 && i == 2) begin
        i_host.hold(1'b1);
        i_host.cyc(12);
        i_host.hold(1'b0);
        chk(o_error === 1'b1 && o_load_complete === 1'b0, "status fault");
        return;
      end
      if (i == n - 1) chk(o_load_complete === 1'b0, "done early");
      i_host.word(d, r);
    end
    i_host.cyc(8);
    if (mode == 2) begin
      chk(o_error === 1'b1 && o_status_n_oe === 1'b1, "overflow");
      return;
    end
    chk(o_load_complete === 1'b1 && exp_q.size() == 0, "image done");
    i_host.finish_load();
    chk(o_init_complete_oe === i_init_done_opt && o_init_complete === 1'b0, "init pull");
    for (t = 0; t < 900 && o_user_mode !== 1'b1; t++) i_host.cyc(1);
    lo = i_user_clk_opt ? (UP - 1) * 20 : INIT - 6;
    hi = i_user_clk_opt ? (UP + 2) * 20 : INIT * 437 / 175;
    chk(t >= lo && t <= hi, "init time");
    chk(o_user_mode === 1'b1 && o_data_pins_user === 1'b1, "user mode");
    chk(o_init_complete_oe === 1'b0, "init released");
    chk(o_status_n_oe === 1'b0 && o_load_complete === 1'b1, "user levels");
  endtask
  initial begin
    logic [31:0] v;
    i_reset_n = 1'b0;
    {i_width_mode, i_decompress_en, i_security_en} = 4'h0;
    {i_user_clk_opt, i_init_done_opt} = 2'h0;
    i_image_words = 32'h1;
    repeat (16) @(negedge i_clk);
    i_reset_n = 1'b1;
    i_host.cyc(20);
    chk(o_status_n_oe === 1'b1 && o_load_complete === 1'b0, "power-on");
    for (int k = 0; k < 12; k++) begin
      v = rnd();
      {i_width_mode, i_decompress_en, i_security_en} = k[3:0];
      i_user_clk_opt = (k < 2) ? k[0] : v[0];
      i_init_done_opt = (k < 2) ? !k[0] : v[1];
      run_cfg((k == 0) ? 1 : 1 + int'(v[7:2] % 6'h5), (k == 1) ? 100 : 0, 0);
      $display("test %0d done", k);
    end
    i_width_mode = 2'h1;
    run_cfg(4, 0, 1);
    $display("status fault test done");
    run_cfg(33, 0, 2);
    $display("overflow test done");
    i_reset_n = 1'b0;
    i_host.cyc(2);
    i_reset_n = 1'b1;
    run_cfg(3, 0, 0);
    $display("reset rerun done");
    stop_test();
  end
  initial begin
    #480000;
    bad_count++;
    $display("MISMATCH %0t watchdog", $time);
    stop_test();
  end
endmodule
